/* File: hdl/cpu_state_map.vh */
`ifndef CPU_STATE_MAP_VH
`define CPU_STATE_MAP_VH

// Register byte offsets on the AXI4-Lite bus
`define OFS_PSW        8'h00
`define OFS_SP         8'h04
`define OFS_SB         8'h08
`define OFS_BSC        8'h0C
`define OFS_PCON       8'h10
`define OFS_IP         8'h14
`define OFS_STAT       8'h18

// Status word field positions
`define PSW_IS1        7
`define PSW_IS0        6
`define PSW_EMB        5
`define PSW_ERB        4
`define PSW_C          3
`define PSW_WR_MASK    8'hF8

// Power control fields
`define PCON_OSC_OFF   3
`define PCON_DIV4      2'h0
`define PCON_DIV8      2'h1
`define PCON_DIV64     2'h2

// Reset values
`define RST_PSW        8'h00
`define RST_SP         8'h00
`define RST_SB         8'h00
`define RST_BSC        16'h0000
`define RST_PCON       4'h0
`define RST_VECTOR     12'h000

// Program memory map
`define PM_GP_LO       12'h010
`define PM_REF_LO      12'h020
`define PM_REF_HI      12'h07F

// Data memory layout
`define BANK_LOW       4'h0
`define BANK_ONE       4'h1
`define BANK_IO        4'hF
`define BSC_BASE       6'h30
`define WINDOW_SPLIT   8'h80

// Sequencer operations
`define OP_NEXT        3'h0
`define OP_REF         3'h1
`define OP_JUMP        3'h2
`define OP_CALL        3'h3
`define OP_INTR        3'h4
`define OP_RET         3'h5
`define OP_PUSH_SB     3'h6
`define OP_POP_SB      3'h7

// Data access widths
`define W_BIT          2'h0
`define W_NIB          2'h1
`define W_BYTE         2'h2
`define W_BSCBIT       2'h3

// Data access spaces
`define SP_MEM         2'h0
`define SP_REG         2'h1
`define SP_PSW         2'h2

// Arithmetic operations
`define ALU_ADD        3'h0
`define ALU_SUB        3'h1
`define ALU_AND        3'h2
`define ALU_OR         3'h3
`define ALU_XOR        3'h4
`define ALU_RL         3'h5
`define ALU_RR         3'h6

`define AXI_OKAY       2'h0
`define AXI_SLVERR     2'h2

`endif

/* File: hdl/cpu_state_bank.v */
`timescale 1ns/1ns
`default_nettype none
`include "cpu_state_map.vh"

module cpu_state_bank (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        seq_valid,
  output wire        seq_ready,
  input  wire [2:0]  seq_op,
  input  wire [1:0]  instr_len,
  input  wire [11:0] target_addr,
  input  wire [11:0] vector_addr,
  output reg  [11:0] instr_pointer,
  output wire [1:0]  pm_region,
  input  wire        dm_req,
  input  wire        dm_we,
  input  wire [1:0]  dm_space,
  input  wire [1:0]  dm_width,
  input  wire [7:0]  dm_addr,
  input  wire [1:0]  dm_bit,
  input  wire [3:0]  bsc_index,
  input  wire [7:0]  dm_wdata,
  output reg  [7:0]  dm_rdata,
  output reg         dm_rvalid,
  input  wire        carry_we,
  input  wire        carry_val,
  input  wire        skip_we,
  input  wire [2:0]  skip_val,
  input  wire        alu_req,
  input  wire [2:0]  alu_op,
  input  wire        alu_wide,
  input  wire [7:0]  alu_a,
  input  wire [7:0]  alu_b,
  input  wire        alu_cin,
  output reg  [7:0]  alu_result,
  output reg         alu_cout,
  output reg         alu_done,
  output reg         cpu_tick
);

  reg  [3:0]  mem [0:511];
  reg  [7:0]  psw_q;
  reg  [7:0]  sp_q;
  reg  [7:0]  sb_q;
  reg  [15:0] bsc_q;
  reg  [3:0]  pcon_q;

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave

  reg         aw_got_q;
  reg         w_got_q;
  reg  [7:0]  aw_addr_q;
  reg  [31:0] w_data_q;
  reg  [3:0]  w_strb_q;
  wire        wr_fire = aw_got_q && w_got_q && !s_axi_bvalid;
  wire        wr_map  = aw_addr_q == `OFS_PSW || aw_addr_q == `OFS_SP || aw_addr_q == `OFS_SB ||
                        aw_addr_q == `OFS_BSC || aw_addr_q == `OFS_PCON;
  wire        wr_b0   = wr_fire && w_strb_q[0];

  assign s_axi_awready = !aw_got_q;
  assign s_axi_wready  = !w_got_q;
  assign s_axi_arready = !s_axi_rvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q     <= 1'b0;
      w_got_q      <= 1'b0;
      aw_addr_q    <= 8'h00;
      w_data_q     <= 32'h0000_0000;
      w_strb_q     <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `AXI_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_got_q) begin
        aw_got_q  <= 1'b1;
        aw_addr_q <= {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && !w_got_q) begin
        w_got_q  <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_got_q     <= 1'b0;
        w_got_q      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_map ? `AXI_OKAY : `AXI_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Stack sequencing

  localparam ST_IDLE = 2'h0;
  localparam ST_PUSH = 2'h1;
  localparam ST_POP  = 2'h2;

  reg  [1:0]  st_q;
  reg  [1:0]  cnt_q;
  reg         sb_only_q;
  reg  [11:0] ret_q;
  reg  [11:0] dest_q;
  reg  [7:0]  pop_lo_q;
  reg  [7:0]  push_byte;
  wire [7:0]  sp_dec  = sp_q - 8'h02;
  wire [8:0]  stk_wr  = {1'b0, sp_dec};
  wire [8:0]  stk_rd  = {1'b0, sp_q};
  wire [7:0]  pop_byte = {mem[stk_rd | 9'h001], mem[stk_rd]};
  wire        seq_go  = seq_valid && seq_ready;

  assign seq_ready = st_q == ST_IDLE;

  // Call/interrupt frame: upper pointer nibble first, status word last
  always @* begin
    case (cnt_q)
      2'h2:    push_byte = {4'h0, ret_q[11:8]};
      2'h1:    push_byte = ret_q[7:0];
      default: push_byte = sb_only_q ? sb_q : psw_q;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      st_q          <= ST_IDLE;
      cnt_q         <= 2'h0;
      sb_only_q     <= 1'b0;
      ret_q         <= 12'h000;
      dest_q        <= 12'h000;
      pop_lo_q      <= 8'h00;
      instr_pointer <= `RST_VECTOR;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (seq_go) begin
            sb_only_q <= 1'b0;
            case (seq_op)
              `OP_NEXT: instr_pointer <= instr_pointer + {10'h000, instr_len};
              `OP_REF:  instr_pointer <= instr_pointer;
              `OP_JUMP: instr_pointer <= target_addr;
              `OP_CALL: begin
                ret_q  <= instr_pointer + {10'h000, instr_len};
                dest_q <= target_addr;
                cnt_q  <= 2'h2;
                st_q   <= ST_PUSH;
              end
              `OP_INTR: begin
                ret_q  <= instr_pointer;
                dest_q <= vector_addr;
                cnt_q  <= 2'h2;
                st_q   <= ST_PUSH;
              end
              `OP_RET: begin
                cnt_q <= 2'h2;
                st_q  <= ST_POP;
              end
              `OP_PUSH_SB: begin
                sb_only_q <= 1'b1;
                cnt_q     <= 2'h0;
                st_q      <= ST_PUSH;
              end
              default: begin
                sb_only_q <= 1'b1;
                cnt_q     <= 2'h0;
                st_q      <= ST_POP;
              end
            endcase
          end
        end
        ST_PUSH: begin
          cnt_q <= cnt_q - 2'h1;
          if (cnt_q == 2'h0) begin
            st_q <= ST_IDLE;
            if (!sb_only_q) begin
              instr_pointer <= dest_q;
            end
          end
        end
        ST_POP: begin
          cnt_q <= cnt_q - 2'h1;
          if (cnt_q == 2'h1) begin
            pop_lo_q <= pop_byte;
          end
          if (cnt_q == 2'h0) begin
            st_q <= ST_IDLE;
            if (!sb_only_q) begin
              instr_pointer <= {pop_byte[3:0], pop_lo_q};
            end
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // Pop order is reverse of push: status/bank byte, then pointer low, then high
  wire pop_status = st_q == ST_POP && (sb_only_q ? 1'b1 : cnt_q == 2'h2);

  assign pm_region = instr_pointer < `PM_GP_LO  ? 2'h0 :
                     instr_pointer < `PM_REF_LO ? 2'h1 :
                     instr_pointer <= `PM_REF_HI ? 2'h2 : 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Data access decode

  wire       bank_span_enable     = psw_q[`PSW_EMB];
  wire [3:0] memory_bank_select     = sb_q[7:4];
  wire [1:0] reg_bnk = psw_q[`PSW_ERB] ? sb_q[1:0] : 2'h0;
  wire       byte_w  = dm_width == `W_BYTE;
  wire [7:0] lo_addr = byte_w ? {dm_addr[7:1], 1'b0} : dm_addr;
  wire [3:0] bank    = bank_span_enable ? memory_bank_select : (dm_addr < `WINDOW_SPLIT ? `BANK_LOW : `BANK_IO);
  wire       is_reg  = dm_space == `SP_REG;
  wire       is_psw  = dm_space == `SP_PSW;
  wire       ram_hit = is_reg || (dm_space == `SP_MEM && (bank == `BANK_LOW || bank == `BANK_ONE));
  wire       bsc_hit = dm_width == `W_BSCBIT ||
                       (dm_space == `SP_MEM && bank == `BANK_IO && dm_addr[7:2] == `BSC_BASE);
  wire [8:0] nib0    = is_reg ? {4'h0, reg_bnk, dm_addr[2:1], byte_w ? 1'b0 : dm_addr[0]}
                              : {bank == `BANK_ONE, lo_addr};
  wire [8:0] nib1    = nib0 | 9'h001;
  wire [3:0] ram_old = mem[nib0];
  wire [1:0] bsc_sel = byte_w ? {dm_addr[1], 1'b0} : dm_addr[1:0];
  wire [3:0] bsc_n0  = bsc_q[{bsc_sel, 2'b00} +: 4];
  wire [3:0] bsc_n1  = bsc_q[{bsc_sel | 2'h1, 2'b00} +: 4];
  wire [3:0] psw_nib = dm_addr[0] ? psw_q[3:0] : psw_q[7:4];
  wire [3:0] new0    = dm_width == `W_BIT ? (ram_old & ~(4'h1 << dm_bit)) | ({3'h0, dm_wdata[0]} << dm_bit)
                                          : dm_wdata[3:0];
  wire       dm_wr   = dm_req && dm_we;

  always @(posedge aclk) begin
    if (st_q == ST_PUSH) begin
      mem[stk_wr]          <= push_byte[3:0];
      mem[stk_wr | 9'h001] <= push_byte[7:4];
    end else if (dm_wr && ram_hit) begin
      mem[nib0] <= new0;
      if (byte_w) begin
        mem[nib1] <= dm_wdata[7:4];
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      dm_rdata  <= 8'h00;
      dm_rvalid <= 1'b0;
    end else begin
      dm_rvalid <= dm_req && !dm_we;
      if (dm_req && !dm_we) begin
        if (is_psw) begin
          // Skip flags only show through a byte read
          dm_rdata <= byte_w ? psw_q : {4'h0, dm_addr[0] ? {psw_nib[3], 3'h0} : psw_nib};
        end else if (dm_width == `W_BSCBIT) begin
          dm_rdata <= {7'h00, bsc_q[bsc_index]};
        end else if (bsc_hit) begin
          dm_rdata <= byte_w ? {bsc_n1, bsc_n0} : {7'h00, dm_width == `W_BIT ? bsc_n0[dm_bit] : 1'b0} |
                      (dm_width == `W_NIB ? {4'h0, bsc_n0} : 8'h00);
        end else if (ram_hit) begin
          dm_rdata <= byte_w ? {mem[nib1], ram_old} :
                      dm_width == `W_BIT ? {7'h00, ram_old[dm_bit]} : {4'h0, ram_old};
        end else begin
          dm_rdata <= 8'h00;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control registers; hardware updates win over bus writes

  wire [3:0] psw_wn  = dm_width == `W_BIT ? (psw_nib & ~(4'h1 << dm_bit)) | ({3'h0, dm_wdata[0]} << dm_bit)
                                          : dm_wdata[3:0];
  wire       psw_dmw = dm_wr && is_psw && !byte_w;

  always @(posedge aclk) begin
    if (!aresetn) begin
      psw_q <= `RST_PSW;
    end else begin
      if (pop_status && !sb_only_q) begin
        psw_q <= pop_byte;
      end else begin
        if (psw_dmw && !dm_addr[0]) begin
          psw_q[7:4] <= psw_wn;
        end else if (wr_b0 && aw_addr_q == `OFS_PSW) begin
          psw_q[7:4] <= w_data_q[7:4];
        end
        if (carry_we) begin
          psw_q[`PSW_C] <= carry_val;
        end else if (psw_dmw && dm_addr[0]) begin
          psw_q[`PSW_C] <= psw_wn[3];
        end else if (wr_b0 && aw_addr_q == `OFS_PSW) begin
          psw_q[`PSW_C] <= w_data_q[`PSW_C];
        end
        if (skip_we) begin
          psw_q[2:0] <= skip_val;
        end
      end
    end
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      sp_q <= `RST_SP;
      sb_q <= `RST_SB;
    end else begin
      if (st_q == ST_PUSH) begin
        sp_q <= sp_dec;
      end else if (st_q == ST_POP) begin
        sp_q <= sp_q + 8'h02;
      end else if (wr_b0 && aw_addr_q == `OFS_SP) begin
        sp_q <= {w_data_q[7:1], 1'b0};
      end
      if (pop_status && sb_only_q) begin
        sb_q <= pop_byte;
      end else if (wr_b0 && aw_addr_q == `OFS_SB) begin
        sb_q <= {w_data_q[7:4], 2'h0, w_data_q[1:0]};
      end
    end
  end

  // Bit carrier: direct nibble/byte, single bit, or indexed bit
  always @(posedge aclk) begin
    if (!aresetn) begin
      bsc_q <= `RST_BSC;
    end else if (dm_wr && dm_width == `W_BSCBIT) begin
      bsc_q[bsc_index] <= dm_wdata[0];
    end else if (dm_wr && bsc_hit) begin
      if (dm_width == `W_BIT) begin
        bsc_q[{bsc_sel, dm_bit}] <= dm_wdata[0];
      end else begin
        bsc_q[{bsc_sel, 2'b00} +: 4] <= dm_wdata[3:0];
        if (byte_w) begin
          bsc_q[{bsc_sel | 2'h1, 2'b00} +: 4] <= dm_wdata[7:4];
        end
      end
    end else if (wr_fire && aw_addr_q == `OFS_BSC) begin
      if (w_strb_q[0]) begin
        bsc_q[7:0] <= w_data_q[7:0];
      end
      if (w_strb_q[1]) begin
        bsc_q[15:8] <= w_data_q[15:8];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // CPU clock divider

  reg [5:0] div_q;
  wire [5:0] div_top = pcon_q[1:0] == `PCON_DIV8  ? 6'h07 :
                       pcon_q[1:0] == `PCON_DIV64 ? 6'h3F : 6'h03;

  always @(posedge aclk) begin
    if (!aresetn) begin
      pcon_q   <= `RST_PCON;
      div_q    <= 6'h00;
      cpu_tick <= 1'b0;
    end else begin
      if (wr_b0 && aw_addr_q == `OFS_PCON) begin
        pcon_q <= w_data_q[3:0];
        div_q  <= 6'h00;
      end else if (pcon_q[`PCON_OSC_OFF]) begin
        div_q <= 6'h00;
      end else begin
        div_q <= div_q >= div_top ? 6'h00 : div_q + 6'h01;
      end
      cpu_tick <= !pcon_q[`PCON_OSC_OFF] && div_q >= div_top;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Arithmetic unit: wide operations hold one extra cycle

  reg        alu_wait_q;
  reg  [8:0] alu_calc;

  always @* begin
    case (alu_op)
      `ALU_ADD: alu_calc = {1'b0, alu_a} + {1'b0, alu_b} + {8'h00, alu_cin};
      `ALU_SUB: alu_calc = {1'b0, alu_a} - {1'b0, alu_b} - {8'h00, alu_cin};
      `ALU_AND: alu_calc = {1'b0, alu_a & alu_b};
      `ALU_OR:  alu_calc = {1'b0, alu_a | alu_b};
      `ALU_XOR: alu_calc = {1'b0, alu_a ^ alu_b};
      `ALU_RL:  alu_calc = alu_wide ? {alu_a[7], alu_a[6:0], alu_a[7]} : {5'h00, alu_a[2:0], alu_a[3]};
      `ALU_RR:  alu_calc = alu_wide ? {alu_a[0], alu_a[0], alu_a[7:1]} : {5'h00, alu_a[0], alu_a[3:1]};
      default:  alu_calc = 9'h000;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      alu_result <= 8'h00;
      alu_cout   <= 1'b0;
      alu_done   <= 1'b0;
      alu_wait_q <= 1'b0;
    end else begin
      alu_done   <= (alu_req && !alu_wide && !alu_wait_q) || alu_wait_q;
      alu_wait_q <= alu_req && alu_wide && !alu_wait_q;
      if (alu_req && !alu_wait_q) begin
        alu_result <= alu_wide ? alu_calc[7:0] : {4'h0, alu_calc[3:0]};
        alu_cout   <= alu_wide ? alu_calc[8] :
                      (alu_op == `ALU_ADD ? (alu_a[3:0] + alu_b[3:0] + {3'h0, alu_cin}) > 5'h0F :
                       alu_op == `ALU_SUB ? {1'b0, alu_a[3:0]} < ({1'b0, alu_b[3:0]} + {4'h0, alu_cin}) :
                       alu_op == `ALU_RR ? alu_a[0] : alu_op == `ALU_RL ? alu_a[3] : 1'b0);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read port

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `AXI_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `AXI_OKAY;
      case ({s_axi_araddr[7:2], 2'b00})
        `OFS_PSW:  s_axi_rdata <= {24'h000000, psw_q};
        `OFS_SP:   s_axi_rdata <= {24'h000000, sp_q};
        `OFS_SB:   s_axi_rdata <= {24'h000000, sb_q};
        `OFS_BSC:  s_axi_rdata <= {16'h0000, bsc_q};
        `OFS_PCON: s_axi_rdata <= {28'h0000000, pcon_q};
        `OFS_IP:   s_axi_rdata <= {20'h00000, instr_pointer};
        `OFS_STAT: s_axi_rdata <= {26'h0000000, pm_region, st_q, 2'h0};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= `AXI_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule
`default_nettype wire

/* File: verification/cpu_state_bank_assertions.sv */
`timescale 1ns/1ns
`default_nettype none
`include "cpu_state_map.vh"
module cpu_state_bank_assertions (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        seq_valid,
  input wire logic        seq_ready,
  input wire logic [2:0]  seq_op,
  input wire logic [1:0]  instr_len,
  input wire logic [11:0] instr_pointer,
  input wire logic [1:0]  pm_region,
  input wire logic        dm_req,
  input wire logic        dm_we,
  input wire logic        dm_rvalid,
  input wire logic        alu_req,
  input wire logic        alu_wide,
  input wire logic        alu_done,
  input wire logic        cpu_tick
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire logic go = seq_valid && seq_ready;
  ////////////////////////////////////////////////////////////////////////////////
  a_ip_step: assert property (go && seq_op == `OP_NEXT |=>
    instr_pointer == $past(instr_pointer) + 12'($past(instr_len))) else $error("pointer step wrong");
  a_ip_ref: assert property (go && seq_op == `OP_REF |=> $stable(instr_pointer))
    else $error("lookup fetch moved pointer");
  a_stack_busy: assert property (go && (seq_op == `OP_CALL || seq_op == `OP_INTR || seq_op == `OP_RET)
    |=> !seq_ready [*3] ##1 seq_ready) else $error("stack sequence length wrong");
  a_sb_busy: assert property (go && seq_op[2:1] == 2'b11 |=> !seq_ready ##1 seq_ready)
    else $error("bank push or pop length wrong");
  a_sp_even: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == `OFS_SP |=>
    s_axi_rdata[0] == 1'b0) else $error("stack pointer bit 0 set");
  a_ref_area: assert property (instr_pointer >= `PM_REF_LO && instr_pointer <= `PM_REF_HI |->
    pm_region == 2'h2) else $error("reference area not flagged");
  a_dm_answer: assert property (dm_req && !dm_we |=> dm_rvalid) else $error("data read not answered");
  a_alu_nib: assert property (alu_req && !alu_wide |=> alu_done) else $error("nibble op not done");
  a_alu_wide: assert property (alu_req && alu_wide |=> !alu_done ##1 alu_done)
    else $error("byte op timing wrong");
  a_tick_gap: assert property (cpu_tick |=> !cpu_tick [*3]) else $error("clock tick too soon");
endmodule
`default_nettype wire

/* File: verification/seq_model.sv */
`timescale 1ns/1ns
`default_nettype none
module seq_model (
  input  wire logic        aclk,
  input  wire logic        seq_ready,
  output var  logic        seq_valid,
  output var  logic [2:0]  seq_op,
  output var  logic [1:0]  instr_len,
  output var  logic [11:0] target_addr,
  output var  logic [11:0] vector_addr
);
  initial begin
    seq_valid = 1'b0;
    {seq_op, instr_len, target_addr, vector_addr} = '0;
  end
  // Table jumps and calls are only ever issued with an instruction length of 3
  task automatic issue(input logic [2:0] op, input logic [1:0] len, input logic [11:0] tgt, input int gap);
    repeat (gap) @(posedge aclk);
    seq_valid <= 1'b1;
    {seq_op, instr_len, target_addr, vector_addr} <= {op, len, tgt, tgt};
    do @(posedge aclk); while (seq_ready !== 1'b1);
    seq_valid <= 1'b0;
    // Scrambled once released so a stale payload is never mistaken for a live one
    {seq_op, instr_len, target_addr, vector_addr} <= ~{op, len, tgt, tgt};
    do @(posedge aclk); while (seq_ready !== 1'b1);
    @(posedge aclk);
  endtask
endmodule
`default_nettype wire

/* File: verification/cpu_state_bank_tb.sv */
`timescale 1ns/1ns
`default_nettype none
`include "cpu_state_map.vh"
module cpu_state_bank_tb;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, dm_addr, dm_wdata, alu_a, alu_b;
  logic [31:0] s_axi_wdata;
  logic [3:0]  s_axi_wstrb, bsc_index;
  logic        dm_req, dm_we, carry_we, carry_val, skip_we, alu_req, alu_wide, alu_cin;
  logic [1:0]  dm_space, dm_width, dm_bit;
  logic [2:0]  skip_val, alu_op;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire         seq_valid, seq_ready, dm_rvalid, alu_cout, alu_done, cpu_tick;
  wire [1:0]   s_axi_bresp, s_axi_rresp, pm_region, instr_len;
  wire [2:0]   seq_op;
  wire [31:0]  s_axi_rdata;
  wire [11:0]  instr_pointer, target_addr, vector_addr;
  wire [7:0]   dm_rdata, alu_result;
  int          num_errors = 0;
  int          checked = 0;
  cpu_state_bank uut (.*);
  seq_model seq (.*);
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Responses are always accepted, so bready and rready simply stay high
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ah, wh;
    ah = 1'b1;
    wh = 1'b1;
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wvalid <= 1'b1;
    while (ah || wh) begin
      @(posedge aclk);
      if (ah && s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        ah = 1'b0;
      end
      if (wh && s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        wh = 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(d, e);
  endtask
  task automatic wrchk(input logic [7:0] a, input logic [31:0] w, input logic [31:0] e);
    wr(a, w);
    rdchk(a, e);
  endtask
  task automatic dm(input logic we, input logic [1:0] sp, input logic [1:0] w, input logic [7:0] a,
                    input logic [7:0] d, output logic [7:0] q);
    {dm_req, dm_we, dm_space, dm_width, dm_addr, dm_wdata} <= {1'b1, we, sp, w, a, d};
    @(posedge aclk);
    dm_req <= 1'b0;
    @(posedge aclk);
    q = dm_rdata;
  endtask
  task automatic alu(input logic [2:0] op, input logic w, input logic [7:0] a, input logic [7:0] b);
    {alu_req, alu_op, alu_wide, alu_a, alu_b} <= {1'b1, op, w, a, b};
    @(posedge aclk);
    alu_req <= 1'b0;
    repeat (w ? 2 : 1) @(posedge aclk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0] r;
    for (int i = 0; i < 6; i++) rdchk(8'(i * 4), 32'h0);
    wrchk(`OFS_SP, 32'h37, 32'h36);
    wrchk(`OFS_PSW, 32'hFF, 32'hF8);
    wrchk(`OFS_SB, 32'hFF, 32'hF3);
    wrchk(`OFS_BSC, 32'hA5C3, 32'hA5C3);
    rd(8'h1C, d, r);
    chk(32'(r), 32'(`AXI_SLVERR));
    $display("register test done");
  endtask
  task automatic t_ip;
    logic [35:0] t [8] = '{36'h0_3_000_003_0, 36'h0_1_000_004_0, 36'h1_1_000_004_0, 36'h2_3_01F_01F_1,
                           36'h2_3_020_020_2, 36'h2_3_07F_07F_2, 36'h0_1_000_080_3, 36'h4_1_00A_00A_0};
    for (int i = 0; i < 8; i++) begin
      seq.issue(t[i][34:32], t[i][29:28], t[i][27:16], 1 + i % 3);
      chk(32'(instr_pointer), 32'(t[i][15:4]));
      chk(32'(pm_region), 32'(t[i][1:0]));
    end
    $display("pointer test done");
  endtask
  task automatic t_stack;
    logic [7:0] q;
    wr(`OFS_SP, 32'h0);
    wr(`OFS_PSW, 32'h90);
    seq.issue(`OP_JUMP, 2'h3, 12'h345, 1);
    seq.issue(`OP_CALL, 2'h3, 12'h123, 2);
    chk(32'(instr_pointer), 32'h123);
    rdchk(`OFS_SP, 32'hFA);
    wr(`OFS_PSW, 32'h20);
    wr(`OFS_SB, 32'h0);
    dm(1'b0, `SP_MEM, `W_BYTE, 8'hFE, 8'h0, q);
    chk(32'(q), 32'h03);
    dm(1'b0, `SP_MEM, `W_BYTE, 8'hFA, 8'h0, q);
    chk(32'(q), 32'h90);
    seq.issue(`OP_RET, 2'h1, 12'h0, 1);
    rdchk(`OFS_PSW, 32'h90);
    rdchk(`OFS_SP, 32'h0);
    wr(`OFS_SB, 32'h13);
    seq.issue(`OP_PUSH_SB, 2'h1, 12'h0, 1);
    rdchk(`OFS_SP, 32'hFE);
    wr(`OFS_SB, 32'h0);
    seq.issue(`OP_POP_SB, 2'h1, 12'h0, 3);
    rdchk(`OFS_SB, 32'h13);
    $display("stack test done");
  endtask
  task automatic t_dm;
    logic [7:0] q;
    logic [19:0] t [4] = '{20'h00_10_5, 20'hF0_C0_A, 20'h10_10_7, 20'h20_10_0};
    wr(`OFS_PSW, 32'h0);
    dm(1'b1, `SP_MEM, `W_NIB, 8'h10, 8'h05, q);
    dm(1'b1, `SP_MEM, `W_NIB, 8'hC0, 8'h0A, q);
    wr(`OFS_PSW, 32'h20);
    wr(`OFS_SB, 32'h10);
    dm(1'b1, `SP_MEM, `W_NIB, 8'h10, 8'h07, q);
    for (int i = 0; i < 4; i++) begin
      wr(`OFS_SB, 32'(t[i][19:12]));
      dm(1'b0, `SP_MEM, `W_NIB, t[i][11:4], 8'h0, q);
      chk(32'(q[3:0]), 32'(t[i][3:0]));
    end
    wr(`OFS_PSW, 32'h0);
    dm(1'b1, `SP_REG, `W_BYTE, 8'h02, 8'h5A, q);
    dm(1'b0, `SP_REG, `W_NIB, 8'h03, 8'h0, q);
    chk(32'(q[3:0]), 32'h5);
    wr(`OFS_PSW, 32'h10);
    wr(`OFS_SB, 32'h01);
    dm(1'b1, `SP_REG, `W_NIB, 8'h03, 8'h0C, q);
    wr(`OFS_PSW, 32'h0);
    dm(1'b0, `SP_REG, `W_NIB, 8'h03, 8'h0, q);
    chk(32'(q[3:0]), 32'h5);
    $display("data memory test done");
  endtask
  task automatic t_flags;
    logic [7:0] q;
    {carry_we, carry_val, skip_we, skip_val} <= {3'b111, 3'h5};
    @(posedge aclk);
    {carry_we, skip_we} <= 2'b00;
    @(posedge aclk);
    rdchk(`OFS_PSW, 32'h0D);
    dm(1'b1, `SP_PSW, `W_BYTE, 8'h00, 8'hFF, q);
    rdchk(`OFS_PSW, 32'h0D);
    dm(1'b1, `SP_PSW, `W_NIB, 8'h00, 8'h0A, q);
    rdchk(`OFS_PSW, 32'hAD);
    alu(`ALU_ADD, 1'b0, 8'h09, 8'h08);
    chk(32'({alu_cout, alu_result[3:0]}), 32'h11);
    alu(`ALU_ADD, 1'b1, 8'hF0, 8'h20);
    chk(32'({alu_cout, alu_result}), 32'h110);
    $display("flag and arithmetic test done");
  endtask
  task automatic t_tick;
    int n;
    logic [11:0] t [4] = '{12'h0_20, 12'h1_10, 12'h2_02, 12'h8_00};
    for (int i = 0; i < 4; i++) begin
      wr(`OFS_PCON, 32'(t[i][11:8]));
      repeat (70) @(posedge aclk);
      n = 0;
      repeat (128) begin
        @(posedge aclk);
        n += int'(cpu_tick);
      end
      chk(32'(n), 32'(t[i][7:0]));
    end
    $display("clock divider test done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {dm_req, dm_we, dm_space, dm_width, dm_addr, dm_wdata, dm_bit, bsc_index} = '0;
    {carry_we, carry_val, skip_we, skip_val, alu_req, alu_op, alu_wide, alu_a, alu_b, alu_cin} = '0;
    {s_axi_bready, s_axi_rready, s_axi_wstrb} = {2'b11, 4'hF};
    aresetn = 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs;
    t_ip;
    t_stack;
    t_dm;
    t_flags;
    t_tick;
    end_sim;
  end
  // Whole run is near 1000 cycles; this leaves wide margin
  initial begin
    repeat (8000) @(posedge aclk);
    num_errors++;
    end_sim;
  end
endmodule
bind cpu_state_bank cpu_state_bank_assertions chk_i (.*);
`default_nettype wire
